// [hw/hac_defs.svh]
// register offsets, field positions, reset values and link constants of the haptic config bank
`ifndef HAC_DEFS_SVH
`define HAC_DEFS_SVH

// --------------------------------------------------
// register offsets
// --------------------------------------------------
`define HAC_OFS_AUDIO_PATH_CONTROL 8'h11
`define HAC_OFS_AUDIO_INPUT_FLOOR 8'h12
`define HAC_OFS_AUDIO_INPUT_FULL_SCALE 8'h13
`define HAC_OFS_AUDIO_DRIVE_FLOOR 8'h14
`define HAC_OFS_AUDIO_DRIVE_CEILING 8'h15
`define HAC_OFS_MOTOR_RATED_LEVEL 8'h16
`define HAC_OFS_OVERDRIVE_LIMIT 8'h17
`define HAC_OFS_CAL_LOSS_COMPENSATION 8'h18
`define HAC_OFS_FIRST 8'h11
`define HAC_OFS_LAST 8'h18
`define HAC_NUM_REGS 8

// --------------------------------------------------
// reset values
// --------------------------------------------------
`define HAC_RST_AUDIO_PATH_CONTROL 8'h05
`define HAC_RST_AUDIO_INPUT_FLOOR 8'h19
`define HAC_RST_AUDIO_INPUT_FULL_SCALE 8'hff
`define HAC_RST_AUDIO_DRIVE_FLOOR 8'h19
`define HAC_RST_AUDIO_DRIVE_CEILING 8'hff
`define HAC_RST_MOTOR_RATED_LEVEL 8'h3e
`define HAC_RST_OVERDRIVE_LIMIT 8'h8c
`define HAC_RST_CAL_LOSS_COMPENSATION 8'h0c

// --------------------------------------------------
// audio path control fields
// --------------------------------------------------
`define HAC_PEAK_WINDOW_MSB 3
`define HAC_PEAK_WINDOW_LSB 2
`define HAC_LOWPASS_MSB 1
`define HAC_LOWPASS_LSB 0
`define HAC_CTRL_WRITE_MASK 8'h0f
`define HAC_PEAK_STEP_MS 6'h0a
`define HAC_LOWPASS_HZ_0 8'h64
`define HAC_LOWPASS_HZ_1 8'h7d
`define HAC_LOWPASS_HZ_2 8'h96
`define HAC_LOWPASS_HZ_3 8'hc8

// --------------------------------------------------
// scaling and link
// --------------------------------------------------
`define HAC_FULL_CODE 10'h0ff
`define HAC_SLAVE_ADDR 7'h2d
`define HAC_UNMAPPED_READ 8'h00

`endif

// [hw/hac_pkg.sv]
// types shared by the haptic config bank
package hac_pkg;

    typedef enum logic [2:0] {
        HAC_IDLE,
        HAC_RX,
        HAC_RX_ACK,
        HAC_TX,
        HAC_TX_ACK
    } hac_link_state_e;

    typedef enum logic [1:0] {
        HAC_BYTE_ADDR,
        HAC_BYTE_PTR,
        HAC_BYTE_DATA
    } hac_byte_kind_e;

endpackage

// [hw/hac_cfg_bank.sv]
// haptic audio and calibration configuration bank with its two-wire slave
//
// What this block does
// - peak window field bits 3-2, 10-40 ms
// - lowpass field bits 1-0, 100-200 Hz
// - audio levels below input floor ignored
// - input full scale register caps level
// - audio drive not below drive floor unless input is below input floor (then 0)
// - audio drive not above drive ceiling unless drive floor exceeds it
// - closed loop uses rated level reference
// - calibration reads rated level; host preloads
// - open loop ignores rated level register
// - closed loop overdrive bounded by clamp
// - open loop reference is overdrive clamp
// - calibration stores loss compensation result
// - playback gain times one plus comp/255
// - audio path control at offset 0x11
`timescale 1ns/1ps
`include "hac_defs.svh"

module hac_cfg_bank #(
    parameter logic [6:0] SLAVE_ADDR = `HAC_SLAVE_ADDR
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic loop_closed,
    input wire logic cal_done,
    input wire logic [7:0] cal_comp_value,
    input wire logic [7:0] audio_level_in,
    input wire logic [7:0] audio_drive_req,
    input wire logic [7:0] drive_gain_in,
    output logic [1:0] audio_peak_window,
    output logic [5:0] peak_window_ms,
    output logic [1:0] audio_lowpass_select,
    output logic [7:0] lowpass_hz,
    output logic [7:0] audio_level_used,
    output logic audio_active,
    output logic [7:0] audio_drive_out,
    output logic [7:0] drive_reference,
    output logic [7:0] overdrive_bound,
    output logic [7:0] cal_rated_level,
    output logic [8:0] comp_drive_gain
);

    // --------------------------------------------------
    // decode helpers
    // --------------------------------------------------
    function automatic logic ofs_valid(input logic [7:0] ofs);
        ofs_valid = (ofs >= `HAC_OFS_FIRST) && (ofs <= `HAC_OFS_LAST);
    endfunction

    function automatic logic [2:0] ofs_index(input logic [7:0] ofs);
        logic [7:0] diff;
        diff = ofs - `HAC_OFS_FIRST;
        ofs_index = diff[2:0];
    endfunction

    function automatic logic [7:0] reset_value(input int idx);
        case (idx)
            0: reset_value = `HAC_RST_AUDIO_PATH_CONTROL;
            1: reset_value = `HAC_RST_AUDIO_INPUT_FLOOR;
            2: reset_value = `HAC_RST_AUDIO_INPUT_FULL_SCALE;
            3: reset_value = `HAC_RST_AUDIO_DRIVE_FLOOR;
            4: reset_value = `HAC_RST_AUDIO_DRIVE_CEILING;
            5: reset_value = `HAC_RST_MOTOR_RATED_LEVEL;
            6: reset_value = `HAC_RST_OVERDRIVE_LIMIT;
            default: reset_value = `HAC_RST_CAL_LOSS_COMPENSATION;
        endcase
    endfunction

    // --------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------
    logic [2:0] scl_pipe_reg;
    logic [2:0] sda_pipe_reg;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scl_pipe_reg <= 3'h7;
            sda_pipe_reg <= 3'h7;
        end
        else
        begin
            scl_pipe_reg <= {scl_pipe_reg[1:0], scl_in};
            sda_pipe_reg <= {sda_pipe_reg[1:0], sda_in};
        end
    end

    // edges only look at stages 1 and 2; stage 0 feeds nothing else
    always_comb
    begin
        scl_rise = scl_pipe_reg[1] && !scl_pipe_reg[2];
        scl_fall = !scl_pipe_reg[1] && scl_pipe_reg[2];
        bus_start = scl_pipe_reg[1] && scl_pipe_reg[2] && sda_pipe_reg[2] && !sda_pipe_reg[1];
        bus_stop = scl_pipe_reg[1] && scl_pipe_reg[2] && !sda_pipe_reg[2] && sda_pipe_reg[1];
    end

    // --------------------------------------------------
    // two-wire slave
    // --------------------------------------------------
    hac_pkg::hac_link_state_e state_reg, state_next;
    hac_pkg::hac_byte_kind_e kind_reg, kind_next;
    logic [7:0] shift_reg, shift_next;
    logic [3:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] ptr_reg, ptr_next;
    logic read_mode_reg, read_mode_next;
    logic nack_reg, nack_next;
    logic sda_oe_reg, sda_oe_next;
    logic host_wr;
    logic [7:0] host_wr_ofs;
    logic [7:0] host_wr_data;
    logic [7:0] cfg_reg [0:`HAC_NUM_REGS-1];
    logic [7:0] cfg_next [0:`HAC_NUM_REGS-1];
    logic [7:0] rd_byte;

    // unmapped offsets read as zero and swallow writes
    always_comb
    begin
        rd_byte = `HAC_UNMAPPED_READ;
        if (ofs_valid(ptr_reg))
        begin
            rd_byte = cfg_reg[ofs_index(ptr_reg)];
        end
    end

    always_comb
    begin
        state_next = state_reg;
        kind_next = kind_reg;
        shift_next = shift_reg;
        bit_cnt_next = bit_cnt_reg;
        ptr_next = ptr_reg;
        read_mode_next = read_mode_reg;
        nack_next = nack_reg;
        sda_oe_next = sda_oe_reg;
        host_wr = 1'b0;
        host_wr_ofs = ptr_reg;
        host_wr_data = shift_reg;
        if (bus_start)
        begin
            // repeated start keeps the pointer for write-pointer-then-read
            state_next = hac_pkg::HAC_RX;
            kind_next = hac_pkg::HAC_BYTE_ADDR;
            bit_cnt_next = 4'h0;
            sda_oe_next = 1'b0;
        end
        else if (bus_stop)
        begin
            state_next = hac_pkg::HAC_IDLE;
            sda_oe_next = 1'b0;
        end
        else
        begin
            case (state_reg)
                hac_pkg::HAC_IDLE:
                begin
                    sda_oe_next = 1'b0;
                end
                hac_pkg::HAC_RX:
                begin
                    if (scl_rise && bit_cnt_reg != 4'h8)
                    begin
                        shift_next = {shift_reg[6:0], sda_pipe_reg[1]};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end
                    else if (scl_fall && bit_cnt_reg == 4'h8)
                    begin
                        bit_cnt_next = 4'h0;
                        state_next = hac_pkg::HAC_RX_ACK;
                        sda_oe_next = 1'b1;
                        case (kind_reg)
                            hac_pkg::HAC_BYTE_ADDR:
                            begin
                                read_mode_next = shift_reg[0];
                                if (shift_reg[7:1] != SLAVE_ADDR)
                                begin
                                    state_next = hac_pkg::HAC_IDLE;
                                    sda_oe_next = 1'b0;
                                end
                            end
                            hac_pkg::HAC_BYTE_PTR:
                            begin
                                ptr_next = shift_reg;
                            end
                            default:
                            begin
                                host_wr = 1'b1;
                                ptr_next = ptr_reg + 8'h01;
                            end
                        endcase
                    end
                end
                hac_pkg::HAC_RX_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (kind_reg == hac_pkg::HAC_BYTE_ADDR && read_mode_reg)
                        begin
                            shift_next = rd_byte;
                            ptr_next = ptr_reg + 8'h01;
                            sda_oe_next = !rd_byte[7];
                            state_next = hac_pkg::HAC_TX;
                        end
                        else
                        begin
                            sda_oe_next = 1'b0;
                            state_next = hac_pkg::HAC_RX;
                            kind_next = (kind_reg == hac_pkg::HAC_BYTE_ADDR) ? hac_pkg::HAC_BYTE_PTR
                                                                               : hac_pkg::HAC_BYTE_DATA;
                        end
                    end
                end
                hac_pkg::HAC_TX:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt_reg == 4'h7)
                        begin
                            bit_cnt_next = 4'h0;
                            sda_oe_next = 1'b0;
                            state_next = hac_pkg::HAC_TX_ACK;
                        end
                        else
                        begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            sda_oe_next = !shift_reg[6];
                            bit_cnt_next = bit_cnt_reg + 4'h1;
                        end
                    end
                end
                hac_pkg::HAC_TX_ACK:
                begin
                    if (scl_rise)
                    begin
                        nack_next = sda_pipe_reg[1];
                    end
                    else if (scl_fall)
                    begin
                        if (nack_reg)
                        begin
                            state_next = hac_pkg::HAC_IDLE;
                        end
                        else
                        begin
                            shift_next = rd_byte;
                            ptr_next = ptr_reg + 8'h01;
                            sda_oe_next = !rd_byte[7];
                            state_next = hac_pkg::HAC_TX;
                        end
                    end
                end
                default:
                begin
                    state_next = hac_pkg::HAC_IDLE;
                    sda_oe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= hac_pkg::HAC_IDLE;
            kind_reg <= hac_pkg::HAC_BYTE_ADDR;
            shift_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
            ptr_reg <= 8'h00;
            read_mode_reg <= 1'b0;
            nack_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            kind_reg <= kind_next;
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_next;
            ptr_reg <= ptr_next;
            read_mode_reg <= read_mode_next;
            nack_reg <= nack_next;
            sda_oe_reg <= sda_oe_next;
        end
    end

    // --------------------------------------------------
    // register file
    // --------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < `HAC_NUM_REGS; i++)
        begin
            cfg_next[i] = cfg_reg[i];
        end
        if (host_wr && ofs_valid(host_wr_ofs))
        begin
            cfg_next[ofs_index(host_wr_ofs)] = host_wr_data;
        end
        // control sits at the first index; upper nibble forced low
        cfg_next[ofs_index(`HAC_OFS_AUDIO_PATH_CONTROL)] =
            cfg_next[ofs_index(`HAC_OFS_AUDIO_PATH_CONTROL)] & `HAC_CTRL_WRITE_MASK;
        // calibration result beats a host write landing in the same cycle
        if (cal_done)
        begin
            cfg_next[ofs_index(`HAC_OFS_CAL_LOSS_COMPENSATION)] = cal_comp_value;
        end
    end

    generate
        for (genvar g = 0; g < `HAC_NUM_REGS; g++)
        begin : g_cfg
            always_ff @(posedge clk_sys or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    cfg_reg[g] <= reset_value(g);
                end
                else
                begin
                    cfg_reg[g] <= cfg_next[g];
                end
            end
        end
    endgenerate

    // --------------------------------------------------
    // engine-facing values
    // --------------------------------------------------
    logic [7:0] ctrl;
    logic [7:0] in_floor;
    logic [7:0] in_full;
    logic [7:0] drv_floor;
    logic [7:0] drv_ceil;
    logic [7:0] rated;
    logic [7:0] od_limit;
    logic [7:0] comp;
    logic [1:0] peak_sel_next;
    logic [5:0] peak_ms_next;
    logic [1:0] lp_sel_next;
    logic [7:0] lp_hz_next;
    logic [7:0] level_next;
    logic active_next;
    logic [7:0] drive_next;
    logic [7:0] ref_next;
    logic [16:0] gain_prod;
    logic [16:0] gain_quot;
    logic [8:0] gain_next;

    always_comb
    begin
        ctrl = cfg_reg[ofs_index(`HAC_OFS_AUDIO_PATH_CONTROL)];
        in_floor = cfg_reg[ofs_index(`HAC_OFS_AUDIO_INPUT_FLOOR)];
        in_full = cfg_reg[ofs_index(`HAC_OFS_AUDIO_INPUT_FULL_SCALE)];
        drv_floor = cfg_reg[ofs_index(`HAC_OFS_AUDIO_DRIVE_FLOOR)];
        drv_ceil = cfg_reg[ofs_index(`HAC_OFS_AUDIO_DRIVE_CEILING)];
        rated = cfg_reg[ofs_index(`HAC_OFS_MOTOR_RATED_LEVEL)];
        od_limit = cfg_reg[ofs_index(`HAC_OFS_OVERDRIVE_LIMIT)];
        comp = cfg_reg[ofs_index(`HAC_OFS_CAL_LOSS_COMPENSATION)];
        peak_sel_next = ctrl[`HAC_PEAK_WINDOW_MSB:`HAC_PEAK_WINDOW_LSB];
        peak_ms_next = `HAC_PEAK_STEP_MS * ({4'h0, peak_sel_next} + 6'h01);
        lp_sel_next = ctrl[`HAC_LOWPASS_MSB:`HAC_LOWPASS_LSB];
        case (lp_sel_next)
            2'h0: lp_hz_next = `HAC_LOWPASS_HZ_0;
            2'h1: lp_hz_next = `HAC_LOWPASS_HZ_1;
            2'h2: lp_hz_next = `HAC_LOWPASS_HZ_2;
            default: lp_hz_next = `HAC_LOWPASS_HZ_3;
        endcase
        // input level clipped to the programmed full scale
        level_next = (audio_level_in > in_full) ? in_full : audio_level_in;
        active_next = (audio_level_in >= in_floor);
        // floor applied after ceiling so a floor above ceiling still wins
        drive_next = (audio_drive_req > drv_ceil) ? drv_ceil : audio_drive_req;
        drive_next = (drive_next < drv_floor) ? drv_floor : drive_next;
        if (!active_next)
        begin
            drive_next = 8'h00;
        end
        ref_next = loop_closed ? rated : od_limit;
        // gain * (255 + comp) / 255 is the same as gain * (1 + comp/255)
        gain_prod = {9'h000, drive_gain_in} * ({9'h000, comp} + {7'h00, `HAC_FULL_CODE});
        gain_quot = gain_prod / {7'h00, `HAC_FULL_CODE};
        gain_next = gain_quot[8:0];
    end

    logic sda_out_reg;
    logic [1:0] peak_sel_reg;
    logic [5:0] peak_ms_reg;
    logic [1:0] lp_sel_reg;
    logic [7:0] lp_hz_reg;
    logic [7:0] level_reg;
    logic active_reg;
    logic [7:0] drive_reg;
    logic [7:0] ref_reg;
    logic [7:0] od_bound_reg;
    logic [7:0] cal_rated_reg;
    logic [8:0] gain_reg;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sda_out_reg <= 1'b0;
            peak_sel_reg <= 2'h1;
            peak_ms_reg <= 6'h14;
            lp_sel_reg <= 2'h1;
            lp_hz_reg <= `HAC_LOWPASS_HZ_1;
            level_reg <= 8'h00;
            active_reg <= 1'b0;
            drive_reg <= 8'h00;
            ref_reg <= 8'h00;
            od_bound_reg <= `HAC_RST_OVERDRIVE_LIMIT;
            cal_rated_reg <= `HAC_RST_MOTOR_RATED_LEVEL;
            gain_reg <= 9'h000;
        end
        else
        begin
            sda_out_reg <= 1'b0;
            peak_sel_reg <= peak_sel_next;
            peak_ms_reg <= peak_ms_next;
            lp_sel_reg <= lp_sel_next;
            lp_hz_reg <= lp_hz_next;
            level_reg <= level_next;
            active_reg <= active_next;
            drive_reg <= drive_next;
            ref_reg <= ref_next;
            od_bound_reg <= od_limit;
            cal_rated_reg <= rated;
            gain_reg <= gain_next;
        end
    end

    assign sda_out = sda_out_reg;
    assign sda_oe = sda_oe_reg;
    assign audio_peak_window = peak_sel_reg;
    assign peak_window_ms = peak_ms_reg;
    assign audio_lowpass_select = lp_sel_reg;
    assign lowpass_hz = lp_hz_reg;
    assign audio_level_used = level_reg;
    assign audio_active = active_reg;
    assign audio_drive_out = drive_reg;
    assign drive_reference = ref_reg;
    assign overdrive_bound = od_bound_reg;
    assign cal_rated_level = cal_rated_reg;
    assign comp_drive_gain = gain_reg;

endmodule // hac_cfg_bank

// [verification/hac_cfg_bank_properties.sv]
// port checker for the haptic config bank
`timescale 1ns/1ps
module hac_cfg_bank_checker (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic loop_closed,
    input wire logic cal_done,
    input wire logic [7:0] cal_comp_value,
    input wire logic [7:0] audio_level_in,
    input wire logic [7:0] drive_gain_in,
    input wire logic [1:0] audio_peak_window,
    input wire logic [5:0] peak_window_ms,
    input wire logic [1:0] audio_lowpass_select,
    input wire logic [7:0] lowpass_hz,
    input wire logic [7:0] audio_level_used,
    input wire logic audio_active,
    input wire logic [7:0] audio_drive_out,
    input wire logic [7:0] drive_reference,
    input wire logic [7:0] overdrive_bound,
    input wire logic [7:0] cal_rated_level,
    input wire logic [8:0] comp_drive_gain
);
    // ----------------------------------------
    // helpers and assertions
    // ----------------------------------------
    logic up_reg;
    logic [7:0] lp_exp;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    always_comb
    begin
        case (audio_lowpass_select)
            2'h0: lp_exp = 8'h64;
            2'h1: lp_exp = 8'h7d;
            2'h2: lp_exp = 8'h96;
            default: lp_exp = 8'hc8;
        endcase
    end
    // skip first edge after reset
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            up_reg <= 1'b0;
        else
            up_reg <= 1'b1;
    end
    peak_ms_a: assert property (peak_window_ms == 6'h0a * (6'(audio_peak_window) + 6'h01))
        else $error("peak window time wrong");
    lowpass_a: assert property (lowpass_hz == lp_exp)
        else $error("lowpass corner wrong");
    level_cap_a: assert property (audio_level_used <= $past(audio_level_in))
        else $error("level above input");
    idle_drive_a: assert property (!audio_active |-> audio_drive_out == 8'h00)
        else $error("drive while input below floor");
    closed_ref_a: assert property (up_reg && $past(loop_closed) |-> drive_reference == cal_rated_level)
        else $error("closed loop reference wrong");
    open_ref_a: assert property (up_reg && !$past(loop_closed) |-> drive_reference == overdrive_bound)
        else $error("open loop reference wrong");
    gain_comp_a: assert property (cal_done ##1 (!cal_done && $stable(drive_gain_in)) |=>
        comp_drive_gain == 9'((18'($past(drive_gain_in)) * (18'($past(cal_comp_value, 2)) + 18'h0ff)) / 18'h0ff))
        else $error("compensated gain wrong");
    gain_floor_a: assert property (up_reg |-> comp_drive_gain >= 9'($past(drive_gain_in)))
        else $error("gain below unity");
    cover property (cal_done);
    cover property (audio_active && audio_drive_out != 8'h00);
    cover property (!loop_closed ##2 drive_reference == overdrive_bound);
endmodule // hac_cfg_bank_checker

bind hac_cfg_bank hac_cfg_bank_checker chk_u (
    .clk_sys(clk_sys), .rst_b(rst_b), .loop_closed(loop_closed), .cal_done(cal_done),
    .cal_comp_value(cal_comp_value), .audio_level_in(audio_level_in), .drive_gain_in(drive_gain_in),
    .audio_peak_window(audio_peak_window), .peak_window_ms(peak_window_ms),
    .audio_lowpass_select(audio_lowpass_select), .lowpass_hz(lowpass_hz), .audio_level_used(audio_level_used),
    .audio_active(audio_active), .audio_drive_out(audio_drive_out), .drive_reference(drive_reference),
    .overdrive_bound(overdrive_bound), .cal_rated_level(cal_rated_level), .comp_drive_gain(comp_drive_gain)
);

// [verification/hac_host_model.sv]
// two-wire host master that reaches the config bank registers
`timescale 1ns/1ps
module hac_host_model (
    input wire logic clk_sys,
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    // ----------------------------------------
    // bus phases, 6+4 low and 8 high clocks
    // ----------------------------------------
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // p low: start or repeated start; p high: stop
    task automatic frame(input logic p);
        hold(6);
        sda_low <= p;
        hold(4);
        scl <= 1'b1;
        hold(8);
        sda_low <= !p;
        hold(8);
        if (!p)
            scl <= 1'b0;
    endtask
    task automatic put_bit(input logic b, output logic r);
        hold(6);
        sda_low <= !b;
        hold(4);
        scl <= 1'b1;
        hold(8);
        r = sda_line;
        scl <= 1'b0;
    endtask
    task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--)
            put_bit(d[i], q[i]);
        put_bit(m, a);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic [2:0] n;
        frame(1'b0);
        xfer({a, 1'b0}, 1'b1, q, n[0]);
        xfer(p, 1'b1, q, n[1]);
        xfer(d, 1'b1, q, n[2]);
        frame(1'b1);
        ok = (n == 3'h0);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] q, output logic ok);
        logic [3:0] n;
        frame(1'b0);
        xfer({a, 1'b0}, 1'b1, q, n[0]);
        xfer(p, 1'b1, q, n[1]);
        frame(1'b0);
        xfer({a, 1'b1}, 1'b1, q, n[2]);
        xfer(8'hff, 1'b1, q, n[3]);
        frame(1'b1);
        ok = (n[2:0] == 3'h0);
    endtask
endmodule // hac_host_model

// [verification/haptic_audio_cal_config_tb.sv]
// self-checking bench for the haptic config bank
`timescale 1ns/1ps
`include "hac_defs.svh"
module haptic_audio_cal_config_tb;
    // ----------------------------------------
    // stimulus, expectations and checks
    // ----------------------------------------
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic scl_in, sda_low, sda_out, sda_oe, active, ok;
    logic loop_closed = 1'b1;
    logic cal_done = 1'b0;
    logic [7:0] comp_in = 8'h00, level_in = 8'h00, req_in = 8'h00, gain_in = 8'h80;
    logic [1:0] peak_sel, lp_sel;
    logic [5:0] peak_ms;
    logic [7:0] lp_hz, lvl_used, drv_out, drv_ref, od_bound, rated_cp, q, e;
    logic [8:0] gain_out;
    logic [7:0] rst_tab [8] = '{8'h05, 8'h19, 8'hff, 8'h19, 8'hff, 8'h3e, 8'h8c, 8'h0c};
    logic [7:0] val_tab [7] = '{8'h20, 8'h80, 8'h30, 8'hc0, 8'h50, 8'h9a, 8'h33};
    logic [7:0] lp_tab [4] = '{8'h64, 8'h7d, 8'h96, 8'hc8};
    logic [7:0] lvl_tab [4] = '{8'h1f, 8'h20, 8'h90, 8'h90};
    logic [7:0] req_tab [4] = '{8'h50, 8'h10, 8'hd0, 8'h50};
    integer miscompares = 0;
    integer check_count = 0;
    // open drain, pulled up
    wire sda_in = !(sda_low || sda_oe);
    always #2.5 clk_sys = ~clk_sys;
    hac_cfg_bank dut_u (
        .clk_sys(clk_sys), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
        .loop_closed(loop_closed), .cal_done(cal_done), .cal_comp_value(comp_in), .audio_level_in(level_in),
        .audio_drive_req(req_in), .drive_gain_in(gain_in), .audio_peak_window(peak_sel), .peak_window_ms(peak_ms),
        .audio_lowpass_select(lp_sel), .lowpass_hz(lp_hz), .audio_level_used(lvl_used), .audio_active(active),
        .audio_drive_out(drv_out), .drive_reference(drv_ref), .overdrive_bound(od_bound),
        .cal_rated_level(rated_cp), .comp_drive_gain(gain_out)
    );
    hac_host_model host_u (.clk_sys(clk_sys), .sda_line(sda_in), .scl(scl_in), .sda_low(sda_low));
    task automatic stop_test;
        if (miscompares == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        host_u.wr(`HAC_SLAVE_ADDR, p, d, ok);
        chk(9'(ok), 9'h001);
    endtask
    task automatic rd(input logic [7:0] p, input logic [7:0] x);
        host_u.rd(`HAC_SLAVE_ADDR, p, q, ok);
        chk({ok, q}, {1'b1, x});
    endtask
    initial
    begin
        tick(8);
        rst_b <= 1'b1;
        tick(4);
        chk(9'(peak_ms), 9'h014);
        chk(9'(lp_hz), 9'h07d);
        for (int i = 0; i < 8; i++)
            rd(8'h11 + 8'(i), rst_tab[i]);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h11, 8'hf0 | 8'(i * 5));
            tick(3);
            chk({1'b0, peak_sel, peak_ms}, {1'b0, 2'(i), 6'((i + 1) * 10)});
            chk({lp_sel == 2'(i), lp_hz}, {1'b1, lp_tab[i]});
            rd(8'h11, 8'(i * 5));
        end
        for (int i = 0; i < 7; i++)
        begin
            wr(8'h12 + 8'(i), val_tab[i]);
            rd(8'h12 + 8'(i), val_tab[i]);
        end
        wr(8'h19, 8'h5a);
        rd(8'h19, 8'h00);
        host_u.wr(7'h2c, 8'h16, 8'h77, ok);
        chk(9'(ok), 9'h000);
        rd(8'h16, 8'h50);
        for (int i = 0; i < 4; i++)
        begin
            level_in <= lvl_tab[i];
            req_in <= req_tab[i];
            tick(3);
            e = req_tab[i] > 8'hc0 ? 8'hc0 : req_tab[i];
            e = e < 8'h30 ? 8'h30 : e;
            chk(9'(lvl_used), 9'(lvl_tab[i] < 8'h80 ? lvl_tab[i] : 8'h80));
            chk(9'(active), 9'(lvl_tab[i] >= 8'h20));
            chk(9'(drv_out), 9'(lvl_tab[i] < 8'h20 ? 8'h00 : e));
        end
        for (int i = 0; i < 2; i++)
        begin
            loop_closed <= 1'(i);
            tick(3);
            chk(9'(drv_ref), 9'(i ? 8'h50 : 8'h9a));
            chk(9'(od_bound), 9'h09a);
        end
        chk(9'(rated_cp), 9'h050);
        cal_done <= 1'b1;
        comp_in <= 8'h44;
        @(posedge clk_sys);
        cal_done <= 1'b0;
        tick(3);
        chk(gain_out, 9'h0a2);
        rd(8'h18, 8'h44);
        gain_in <= 8'hff;
        tick(3);
        chk(gain_out, 9'h143);
        stop_test;
    end
    initial
    begin
        repeat (100000) @(posedge clk_sys);
        miscompares++;
        stop_test;
    end
endmodule // haptic_audio_cal_config_tb
